// ==== rtl/fbmc_host.sv ====
// Host controller for a byte-wide asynchronous flash: modes, commands, powerdown
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] Device refuses alteration at low supply
// [RQ2] Reset low disables all device functions
// [RQ3] Program and erase use two-step commands
// [RQ4] Write mode command before any read
// [RQ5] Device wakes in array read mode
// [RQ6] Read: select, output enable low, strobe high
// [RQ7] Output enable high floats data lines
// [RQ8] Chip select high means standby, floated
// [RQ9] Deselect does not stop running operation
// [RQ10] Reset low gives deep powerdown
// [RQ11] Ready/busy low only while machine works
// [RQ12] Identifier: bit zero picks maker/device code
// [RQ13] Identifier command enters identifier mode
// [RQ14] Identifier reads need no high supply
// [RQ15] Wait wake interval before first read
// [RQ16] Wake resets interface and status pattern
// [RQ17] Reset low aborts program or erase
// [RQ18] Wait recovery interval before command write
// [RQ19] Never output enable and strobe together
// [RQ20] Command written on write strobe rising edge
// [RQ21] Array read command restores array mode
// [RQ22] Identifier decodes only address bit zero
module fbmc_host (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_req,
	input wire fbmc_pkg::fbmc_op_t i_op,
	input wire logic [19:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic o_ready,
	output logic o_done,
	output logic [7:0] o_rdata,
	output logic o_busy_seen,
	input wire logic i_ready_busy_out,
	input wire logic [7:0] i_data_lines,
	output logic [7:0] o_data_lines,
	output logic o_data_lines_oe,
	output logic [19:0] o_addr,
	output logic o_chip_sel_n,
	output logic o_out_en_n,
	output logic o_write_n,
	output logic o_reset_powerdown_n
);
	typedef enum logic [2:0] {
		FBMC_S_WAKE = 3'b000,
		FBMC_S_IDLE = 3'b001,
		FBMC_S_CYC1 = 3'b010,
		FBMC_S_CYC2 = 3'b011,
		FBMC_S_PD = 3'b100
	} fbmc_st_t;
	fbmc_st_t st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [2:0] op_r, op_nxt;
	logic [19:0] addr_r, addr_nxt;
	logic [7:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic done_r, done_nxt, reset_powerdown_n_r, reset_powerdown_n_nxt;
	// Ready/busy pin is asynchronous: two flops before any use
	logic rb_s1_r, rb_s2_r;
	logic go_r, go_nxt;
	logic [19:0] caddr;
	logic [7:0] cdata;
	logic cwr;
	// One engine runs every bus cycle, so strobe timing lives in one place
	fbmc_cyc_if cyc ();

	fbmc_cycle u_cycle (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.cyc(cyc),
		.i_data_lines(i_data_lines),
		.o_chip_sel_n(o_chip_sel_n),
		.o_out_en_n(o_out_en_n),
		.o_write_n(o_write_n),
		.o_addr(o_addr),
		.o_data_lines(o_data_lines),
		.o_data_lines_oe(o_data_lines_oe)
	);

	// Selects what the current bus cycle carries
	always_comb begin
		cwr = 1'b1;
		caddr = addr_r;
		cdata = wd_r;
		case (fbmc_pkg::fbmc_op_t'(op_r))
			fbmc_pkg::FBMC_OP_READ: cwr = 1'b0;
			fbmc_pkg::FBMC_OP_PROGRAM: begin
				// Setup then data: a lone write never alters [RQ3]
				cdata = (st_r == FBMC_S_CYC1) ? fbmc_pkg::CMD_WRITE_SETUP : wd_r;
			end
			fbmc_pkg::FBMC_OP_ERASE: begin
				cdata = (st_r == FBMC_S_CYC1) ? fbmc_pkg::CMD_ERASE_SETUP : fbmc_pkg::CMD_CONFIRM; // [RQ3]
			end
			fbmc_pkg::FBMC_OP_IDENT: begin
				// Mode command first, then read; only bit zero matters [RQ13] [RQ12] [RQ22]
				cwr = (st_r == FBMC_S_CYC1);
				cdata = fbmc_pkg::CMD_IDENT;
				caddr = (st_r == FBMC_S_CYC1) ? '0 : {19'h00000, addr_r[0]};
			end
			fbmc_pkg::FBMC_OP_STATUS: begin
				cwr = (st_r == FBMC_S_CYC1); // [RQ4]
				cdata = fbmc_pkg::CMD_READ_STATUS;
			end
			fbmc_pkg::FBMC_OP_ARRAY: cdata = fbmc_pkg::CMD_READ_ARRAY; // [RQ21]
			default: cdata = wd_r;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		done_nxt = 1'b0;
		reset_powerdown_n_nxt = reset_powerdown_n_r;
		go_nxt = 1'b0;
		case (st_r)
			FBMC_S_WAKE: begin
				// Hold off every access until both wake times pass [RQ15] [RQ18]
				// One shared wait: reads lose a few cycles, counter stays single
				reset_powerdown_n_nxt = 1'b1;
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == 16'(fbmc_pkg::WAKE_CYC)) begin
					st_nxt = FBMC_S_IDLE;
				end
			end
			FBMC_S_IDLE: begin
				if (i_req) begin
					op_nxt = i_op;
					addr_nxt = i_addr;
					wd_nxt = i_wdata;
					cnt_nxt = '0;
					if (i_op == fbmc_pkg::FBMC_OP_POWERDOWN) begin
						// Powerdown also aborts any running operation [RQ10] [RQ17]
						st_nxt = FBMC_S_PD;
						reset_powerdown_n_nxt = 1'b0;
					end else begin
						st_nxt = FBMC_S_CYC1;
						go_nxt = 1'b1;
					end
				end
			end
			FBMC_S_CYC1: begin
				if (cyc.done) begin
					if (op_r == fbmc_pkg::FBMC_OP_READ || op_r == fbmc_pkg::FBMC_OP_CMD ||
						op_r == fbmc_pkg::FBMC_OP_ARRAY) begin
						st_nxt = FBMC_S_IDLE;
						done_nxt = 1'b1;
						rd_nxt = cyc.rdata;
					end else begin
						st_nxt = FBMC_S_CYC2;
						go_nxt = 1'b1;
					end
				end
			end
			FBMC_S_CYC2: begin
				if (cyc.done) begin
					st_nxt = FBMC_S_IDLE;
					done_nxt = 1'b1;
					rd_nxt = cyc.rdata;
				end
			end
			default: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == 16'(fbmc_pkg::PD_CYC)) begin
					// Device returns in array mode; wait out wake time [RQ5] [RQ16]
					st_nxt = FBMC_S_WAKE;
					cnt_nxt = '0;
					done_nxt = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			// Start in powerdown so the first access waits out a wake
			st_r <= FBMC_S_PD;
			cnt_r <= '0;
			op_r <= 3'h0;
			addr_r <= '0;
			wd_r <= '0;
			rd_r <= '0;
			done_r <= 1'b0;
			reset_powerdown_n_r <= 1'b0;
			go_r <= 1'b0;
			rb_s1_r <= 1'b1;
			rb_s2_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			done_r <= done_nxt;
			reset_powerdown_n_r <= reset_powerdown_n_nxt;
			go_r <= go_nxt;
			rb_s1_r <= i_ready_busy_out;
			rb_s2_r <= rb_s1_r;
		end
	end

	assign cyc.start = go_r;
	assign cyc.wr = cwr;
	assign cyc.addr = caddr;
	assign cyc.wdata = cdata;
	// Requests outside idle are dropped, not queued
	assign o_ready = (st_r == FBMC_S_IDLE);
	assign o_done = done_r;
	assign o_rdata = rd_r;
	// Busy only meaningful while awake; device reports ready in powerdown [RQ11]
	assign o_busy_seen = !rb_s2_r;
	assign o_reset_powerdown_n = reset_powerdown_n_r; // [RQ2]
endmodule : fbmc_host
`default_nettype wire

// ==== rtl/fbmc_pkg.sv ====
// Package of constants for the flash bus mode controller (host side)
package fbmc_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned DATA_W = 8;
	// Command bytes
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
	// Identifier addresses
	localparam logic [19:0] ID_MFR_ADDR = 20'h00000;
	localparam logic [19:0] ID_DEV_ADDR = 20'h00001;
	// Wake-up figures in ns; defaults, no device figures quoted
	localparam int unsigned WAKE_TO_OUTPUT_VALID_NS = 400;
	localparam int unsigned WAKE_TO_COMMAND_WRITE_NS = 1000;
	localparam int unsigned WAKE_CYC = (WAKE_TO_COMMAND_WRITE_NS > WAKE_TO_OUTPUT_VALID_NS ?
		WAKE_TO_COMMAND_WRITE_NS : WAKE_TO_OUTPUT_VALID_NS) * (CLK_HZ / 1_000_000) / 1000 + 1;
	// Strobe base (strobe lasts STROBE_CYC + 3 cycles) and powerdown count in cycles; counter width in bits
	localparam int unsigned STROBE_CYC = 4;
	localparam int unsigned PD_CYC = 4;
	localparam int unsigned CNT_W = 8;
	// Operation codes from the user port
	typedef enum logic [2:0] {
		FBMC_OP_READ = 3'b000,
		FBMC_OP_CMD = 3'b001,
		FBMC_OP_PROGRAM = 3'b010,
		FBMC_OP_ERASE = 3'b011,
		FBMC_OP_IDENT = 3'b100,
		FBMC_OP_STATUS = 3'b101,
		FBMC_OP_ARRAY = 3'b110,
		FBMC_OP_POWERDOWN = 3'b111
	} fbmc_op_t;
endpackage : fbmc_pkg

// ==== rtl/fbmc_cyc_if.sv ====
// Interface between the sequencer and the bus-cycle engine
`timescale 1ns/1ps
`default_nettype none
interface fbmc_cyc_if;
	logic start;
	logic wr;
	logic [19:0] addr;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;
	modport seq (output start, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input start, input wr, input addr, input wdata, output done, output rdata);
endinterface : fbmc_cyc_if
`default_nettype wire

// ==== rtl/fbmc_cycle.sv ====
// Single bus-cycle engine: one read or one command write on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fbmc_cycle (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	fbmc_cyc_if.eng cyc,
	input wire logic [7:0] i_data_lines,
	output logic o_chip_sel_n,
	output logic o_out_en_n,
	output logic o_write_n,
	output logic [19:0] o_addr,
	output logic [7:0] o_data_lines,
	output logic o_data_lines_oe
);
	typedef enum logic [1:0] {
		FBMC_C_IDLE = 2'b00,
		FBMC_C_ACT = 2'b01,
		FBMC_C_REL = 2'b10
	} fbmc_cst_t;
	fbmc_cst_t st_r, st_nxt;
	logic [fbmc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic wr_r, wr_nxt;
	logic [19:0] addr_r, addr_nxt;
	logic [7:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [7:0] din_s1_r, din_s2_r;
	logic done_r, done_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		done_nxt = 1'b0;
		case (st_r)
			FBMC_C_IDLE: begin
				if (cyc.start) begin
					st_nxt = FBMC_C_ACT;
					wr_nxt = cyc.wr;
					addr_nxt = cyc.addr;
					wd_nxt = cyc.wdata;
					cnt_nxt = '0;
				end
			end
			FBMC_C_ACT: begin
				cnt_nxt = cnt_r + 1'b1;
				// Extra cycles let the synchronised data settle
				if (cnt_r == fbmc_pkg::CNT_W'(fbmc_pkg::STROBE_CYC + 2)) begin
					st_nxt = FBMC_C_REL;
					if (!wr_r) rd_nxt = din_s2_r;
				end
			end
			default: begin
				// Strobe rises here; address and data still held [RQ20]
				st_nxt = FBMC_C_IDLE;
				done_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r <= FBMC_C_IDLE;
			cnt_r <= '0;
			wr_r <= 1'b0;
			addr_r <= '0;
			wd_r <= '0;
			rd_r <= '0;
			done_r <= 1'b0;
			din_s1_r <= '0;
			din_s2_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			done_r <= done_nxt;
			din_s1_r <= i_data_lines;
			din_s2_r <= din_s1_r;
		end
	end

	// Write and output strobes are never low together [RQ19]
	assign o_chip_sel_n = (st_r == FBMC_C_IDLE);
	assign o_out_en_n = !(st_r == FBMC_C_ACT && !wr_r); // [RQ6]
	assign o_write_n = !(st_r == FBMC_C_ACT && wr_r); // [RQ20]
	assign o_addr = addr_r;
	assign o_data_lines = wd_r;
	assign o_data_lines_oe = (st_r != FBMC_C_IDLE) && wr_r;
	assign cyc.done = done_r;
	assign cyc.rdata = rd_r;
endmodule : fbmc_cycle
`default_nettype wire

// ==== testbench/fbmc_host_asserts.sv ====
// Checker of the host's flash pin sequencing
`timescale 1ns/1ps
`default_nettype none
module fbmc_host_asserts (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic o_chip_sel_n,
	input wire logic o_out_en_n,
	input wire logic o_write_n,
	input wire logic o_data_lines_oe,
	input wire logic o_reset_powerdown_n,
	input wire logic [19:0] o_addr,
	input wire logic [7:0] o_data_lines
);
	logic [7:0] wake_r;
	logic [7:0] wake_nxt;
	// Saturating count of cycles since the device was woken
	always_comb wake_nxt = !o_reset_powerdown_n ? 8'h00 : (wake_r == 8'hff ? wake_r : wake_r + 8'h01);
	always_ff @(posedge i_clk_sys or negedge i_arst_n) if (!i_arst_n) wake_r <= 8'h00; else wake_r <= wake_nxt;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	property p_no_clash; !(!o_out_en_n && !o_write_n); endproperty
	a_no_clash: assert property (p_no_clash) else $error("read and write strobes low together");
	property p_read; !o_out_en_n |-> !o_chip_sel_n && o_write_n && o_reset_powerdown_n && !o_data_lines_oe; endproperty
	a_read: assert property (p_read) else $error("bad read cycle pins");
	property p_write; !o_write_n |-> !o_chip_sel_n && o_data_lines_oe && o_reset_powerdown_n; endproperty
	a_write: assert property (p_write) else $error("bad write cycle pins");
	property p_hold; !o_write_n && $past(!o_write_n) |-> $stable(o_data_lines) && $stable(o_addr); endproperty
	a_hold: assert property (p_hold) else $error("write data moved under strobe");
	property p_wake; !o_write_n || !o_out_en_n |->
		wake_r >= 8'(fbmc_pkg::WAKE_TO_COMMAND_WRITE_NS * (fbmc_pkg::CLK_HZ / 1_000_000) / 1000); endproperty
	a_wake: assert property (p_wake) else $error("access too soon after wake");
	property p_pd; $fell(o_reset_powerdown_n) |-> !o_reset_powerdown_n [*5]; endproperty
	a_pd: assert property (p_pd) else $error("powerdown pulse too short");
	property p_we_width; $fell(o_write_n) |-> !o_write_n [*7] ##1 (o_write_n && !o_chip_sel_n); endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
	property p_oe_width; $fell(o_out_en_n) |-> !o_out_en_n [*7] ##1 (o_out_en_n && !o_chip_sel_n); endproperty
	a_oe_width: assert property (p_oe_width) else $error("read strobe width wrong");
endmodule : fbmc_host_asserts
bind fbmc_host fbmc_host_asserts u_chk (.i_clk_sys, .i_arst_n, .o_chip_sel_n, .o_out_en_n, .o_write_n,
	.o_data_lines_oe, .o_reset_powerdown_n, .o_addr, .o_data_lines);
`default_nettype wire

// ==== testbench/fbmc_flash_model.sv ====
// Behavioural flash device on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module fbmc_flash_model #(
	parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3c // Arbitrary value
) (
	input wire logic i_reset_powerdown_n,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_vpp_high,
	input wire logic [19:0] i_addr,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic o_ready_busy_out
);
	logic [7:0] mem [256];
	logic [7:0] setup = 8'h00;
	logic [1:0] mode = 2'h0;
	logic busy = 1'b0;
	initial foreach (mem[i]) mem[i] = 8'hff;
	always @(negedge i_reset_powerdown_n) begin
		mode = 2'h0;
		setup = 8'h00;
		busy = 1'b0;
	end
	always @(posedge i_we_n) if (i_reset_powerdown_n && !i_ce_n && !busy) begin
		if (setup != 8'h00) begin
			if (i_vpp_high && (setup == 8'h40 || i_data == 8'hd0)) begin
				if (setup == 8'h40) mem[i_addr[7:0]] &= i_data;
				else foreach (mem[i]) mem[i] = 8'hff;
				busy = 1'b1;
				busy <= #2000 1'b0;
			end
			mode = 2'h2;
			setup = 8'h00;
		end else case (i_data)
			8'hff: mode = 2'h0;
			8'h90: mode = 2'h1;
			8'h70: mode = 2'h2;
			8'h40, 8'h20: setup = i_data;
			default: ;
		endcase
	end
	assign o_data_oe = i_reset_powerdown_n && !i_ce_n && !i_oe_n && i_we_n;
	assign o_data = mode == 2'h1 ? (i_addr[0] ? DEV_CODE : MFR_CODE) :
		mode == 2'h2 ? {!busy, 7'h00} : mem[i_addr[7:0]];
	assign o_ready_busy_out = !busy;
endmodule : fbmc_flash_model
`default_nettype wire

// ==== testbench/fbmc_host_bench.sv ====
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fbmc_host_bench;
	localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
	localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
	logic clk = 1'b0, arst_n = 1'b0, req = 1'b0, vpp = 1'b1;
	fbmc_pkg::fbmc_op_t op = fbmc_pkg::FBMC_OP_READ;
	logic [19:0] addr = 20'h00000, h_addr;
	logic [7:0] wdata = 8'h00, rdata, h_dq, m_dq, dq, dq_last = 8'h00, ref_mem [256];
	logic ready, done, busy_seen, h_oe, m_oe, ready_busy, cs_n, oe_n, we_n, reset_powerdown_n;
	int err_count = 0, n_checks = 0, cyc = 0;
	logic [31:0] lfsr = 32'h9424f5d9;
	always #12.5 clk = ~clk;
	// Released bus toggles so a floating read never looks valid
	assign dq = m_oe ? m_dq : h_oe ? h_dq : ~dq_last;
	always @(posedge clk) dq_last <= dq;
	fbmc_host uut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_req(req), .i_op(op), .i_addr(addr), .i_wdata(wdata),
		.o_ready(ready), .o_done(done), .o_rdata(rdata), .o_busy_seen(busy_seen),
		.i_ready_busy_out(ready_busy), .i_data_lines(dq), .o_data_lines(h_dq), .o_data_lines_oe(h_oe),
		.o_addr(h_addr), .o_chip_sel_n(cs_n), .o_out_en_n(oe_n), .o_write_n(we_n),
		.o_reset_powerdown_n(reset_powerdown_n));
	fbmc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.i_reset_powerdown_n(reset_powerdown_n),
		.i_ce_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_vpp_high(vpp), .i_addr(h_addr), .i_data(dq), .o_data(m_dq),
		.o_data_oe(m_oe), .o_ready_busy_out(ready_busy));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	// Identifier code picked by the lowest address bit alone
	function automatic logic [7:0] exp_id(input logic a0);
		return a0 ? DEV : MFR;
	endfunction : exp_id
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic run(input fbmc_pkg::fbmc_op_t o, input logic [19:0] a, input logic [7:0] d);
		for (int n = 0; ready !== 1'b1 && n < 300; n++) @(negedge clk);
		op = o;
		addr = a;
		wdata = d;
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		for (int n = 0; done !== 1'b1 && n < 300; n++) @(negedge clk);
		chk("done", {7'h00, done}, 8'h01);
	endtask : run
	task automatic idle;
		for (int n = 0; busy_seen !== 1'b0 && n < 300; n++) @(negedge clk);
	endtask : idle
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		logic [19:0] a;
		foreach (ref_mem[i]) ref_mem[i] = 8'hff;
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		vpp = 1'b0;
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			a = {lfsr[19:1], i[0]};
			run(fbmc_pkg::FBMC_OP_IDENT, a, 8'h00);
			chk("ident", rdata, exp_id(a[0]));
		end
		run(fbmc_pkg::FBMC_OP_STATUS, 20'h00000, 8'h00);
		chk("status", rdata, 8'h80);
		for (int i = 0; i < 12; i++) begin
			lfsr = nxt(lfsr);
			a = i == 0 ? 20'hfffff : lfsr[19:0];
			vpp = i[0];
			run(fbmc_pkg::FBMC_OP_CMD, a, 8'hd0);
			run(fbmc_pkg::FBMC_OP_PROGRAM, a, lfsr[31:24]);
			repeat (3) @(negedge clk);
			chk("busy", {7'h00, busy_seen}, {7'h00, vpp});
			if (vpp) begin
				ref_mem[a[7:0]] &= lfsr[31:24];
				idle();
			end
			run(fbmc_pkg::FBMC_OP_ARRAY, a, 8'h00);
			run(fbmc_pkg::FBMC_OP_READ, a, 8'h00);
			chk("array", rdata, ref_mem[a[7:0]]);
		end
		run(fbmc_pkg::FBMC_OP_ERASE, a, 8'h00);
		idle();
		run(fbmc_pkg::FBMC_OP_ARRAY, a, 8'h00);
		run(fbmc_pkg::FBMC_OP_READ, a, 8'h00);
		chk("erased", rdata, 8'hff);
		run(fbmc_pkg::FBMC_OP_PROGRAM, a, 8'h00);
		run(fbmc_pkg::FBMC_OP_POWERDOWN, a, 8'h00);
		repeat (3) @(negedge clk);
		chk("abort", {7'h00, busy_seen}, 8'h00);
		run(fbmc_pkg::FBMC_OP_READ, a ^ 20'h00001, 8'h00);
		chk("wake", rdata, 8'hff);
		run(fbmc_pkg::FBMC_OP_STATUS, a, 8'h00);
		chk("wake_status", rdata, 8'h80);
		end_sim();
	end
endmodule : fbmc_host_bench
`default_nettype wire
